//--- design/eeprom_two_wire_slave_front.sv
// two-wire slave front end: conditions, select byte, acknowledge, write trigger
// assumes front_pkg compiled first; scl_clk_i is the bus clock, clk_i runs at 25 MHz
// What this block does
// - Slave only: never starts a transfer, never drives the serial clock.
// - START is data falling while clock stays high.
// - Nothing is answered until a START has been seen.
// - Outside a program cycle START is watched for; during one it is not.
// - STOP is data rising while clock stays high; it ends the exchange.
// - STOP after a read forces standby only after the master's not-acknowledge.
// - STOP ending a write command starts the internal write cycle.
// - Transmitter releases data after 8 bits; receiver pulls low on the 9th clock.
// - Received data is sampled on each rising serial clock edge.
// - Clock and data inputs are glitch filtered, at most 100 ns, for START, STOP and the falling clock; bit capture on the rising edge is not.
// - Select byte: type code, two chip-select bits, block bit, direction bit.
// - Chip-select bits must match the chip-select pins to respond.
// - On a match the select byte is acknowledged on the 9th clock.
// - During a program cycle all requests are ignored and never acknowledged.
`timescale 1ns/10ps
`include "eeprom_front_defines.svh"

module eeprom_two_wire_slave_front #(
  parameter logic [3:0] TYPE_CODE = 4'h6  // arbitrary value
) (
  input  wire logic            clk_i,              // system clock
  input  wire logic            reset_n_i,          // async reset, active low
  input  wire logic            scl_clk_i,          // serial clock from the master
  input  wire logic            sda_i,              // serial data line level
  output logic                 sda_o,              // data drive value, always low
  output logic                 sda_oe_n_o,         // low while pulling data low
  input  wire logic [1:0]      chip_select_pins_i, // chip-select straps
  input  wire logic            write_busy_i,       // program cycle in progress
  input  wire logic [7:0]      tx_data_i,          // next byte to send on a read
  output front_pkg::sel_info_t sel_info_o,         // accepted select byte
  output front_pkg::rx_byte_t  rx_byte_o,          // received write byte
  output logic                 tx_take_o,          // tx_data_i loaded
  output logic                 write_start_o,      // start program cycle pulse
  output logic                 standby_o           // device in standby
);
  import front_pkg::*;
  logic       rst_s1_reg;
  logic       rst_n_reg;
  logic       link_tog_reg;
  logic       link_tog_next;
  logic       link_bit_reg;
  logic       link_bit_next;
  logic [2:0] tog_sync_reg;
  logic [3:0] pin_s1_reg;
  logic [3:0] pin_s2_reg;
  logic [1:0] filt_reg;
  logic [1:0] filt_next;
  logic [1:0] filt_cnt_reg  [2];
  logic [1:0] filt_cnt_next [2];
  logic       scl_p_reg;
  logic       sda_p_reg;
  logic       rise_evt;
  logic       fall_evt;
  logic       start_evt;
  logic       stop_evt;
  logic [1:0] cs_s;
  state_t     state_reg;
  state_t     state_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic       drive_reg;
  logic       drive_next;
  logic       rw_reg;
  logic       rw_next;
  logic       wrote_reg;
  logic       wrote_next;
  logic       nack_reg;
  logic       nack_next;
  sel_info_t  sel_reg;
  sel_info_t  sel_next;
  rx_byte_t   rx_reg;
  rx_byte_t   rx_next;
  logic       tx_take_reg;
  logic       tx_take_next;
  logic       wstart_reg;
  logic       wstart_next;
  logic       standby_reg;
  logic       standby_next;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg  <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg  <= rst_s1_reg;
    end
  end
  // link side: the bus clock stops between frames, so only capture and toggle here
  always_comb begin
    link_tog_next = ~link_tog_reg;
    link_bit_next = sda_i;
  end
  always_ff @(posedge scl_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      link_tog_reg <= 1'b0;
      link_bit_reg <= 1'b0;
    end else begin
      link_tog_reg <= link_tog_next;
      link_bit_reg <= link_bit_next;
    end
  end
  // toggle crossing; link_bit_reg is stable long before the toggle is seen
  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      tog_sync_reg <= 3'h0;
      pin_s1_reg   <= 4'hF;
      pin_s2_reg   <= 4'hF;
    end else begin
      tog_sync_reg <= {tog_sync_reg[1:0], link_tog_reg};
      pin_s1_reg   <= {chip_select_pins_i, sda_i, scl_clk_i};
      pin_s2_reg   <= pin_s1_reg;
    end
  end
  assign rise_evt = tog_sync_reg[2] ^ tog_sync_reg[1];
  assign cs_s     = pin_s2_reg[3:2];
  // line must differ for the whole filter time before it is believed
  for (genvar g = 0; g < 2; g++) begin : g_filt
    always_comb begin
      filt_next[g]     = filt_reg[g];
      filt_cnt_next[g] = 2'h0;
      if (pin_s2_reg[g] != filt_reg[g]) begin
        if (filt_cnt_reg[g] == 2'(`FILT_CYC - 1)) begin
          filt_next[g] = pin_s2_reg[g];
        end else begin
          filt_cnt_next[g] = filt_cnt_reg[g] + 2'h1;
        end
      end
    end
    always_ff @(posedge clk_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
        filt_reg[g]     <= 1'b1;
        filt_cnt_reg[g] <= 2'h0;
      end else begin
        filt_reg[g]     <= filt_next[g];
        filt_cnt_reg[g] <= filt_cnt_next[g];
      end
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      scl_p_reg <= 1'b1;
      sda_p_reg <= 1'b1;
    end else begin
      scl_p_reg <= filt_reg[0];
      sda_p_reg <= filt_reg[1];
    end
  end
  assign fall_evt  = scl_p_reg & ~filt_reg[0];
  assign start_evt = scl_p_reg & filt_reg[0] & sda_p_reg & ~filt_reg[1];
  assign stop_evt  = scl_p_reg & filt_reg[0] & ~sda_p_reg & filt_reg[1];
  always_comb begin
    state_next      = state_reg;
    cnt_next        = cnt_reg;
    shift_next      = shift_reg;
    drive_next      = drive_reg;
    rw_next         = rw_reg;
    wrote_next      = wrote_reg;
    nack_next       = nack_reg;
    sel_next        = sel_reg;
    sel_next.valid  = 1'b0;
    rx_next         = rx_reg;
    rx_next.valid   = 1'b0;
    tx_take_next    = 1'b0;
    wstart_next     = 1'b0;
    standby_next    = standby_reg;
    if (write_busy_i) begin
      state_next = ST_IDLE;
      wrote_next = 1'b0;
    end else if (start_evt) begin
      state_next   = ST_SELECT;
      cnt_next     = 4'h0;
      rw_next      = 1'b0;
      wrote_next   = 1'b0;
      nack_next    = 1'b0;
      standby_next = 1'b0;
    end else if (stop_evt) begin
      wstart_next = wrote_reg;
      wrote_next  = 1'b0;
      if (rw_reg && !nack_reg && state_reg != ST_IDLE) begin
        state_next = ST_WAIT;
      end else begin
        state_next   = ST_IDLE;
        standby_next = 1'b1;
      end
    end else begin
      case (state_reg)
        ST_SELECT, ST_WRITE_RX: begin
          if (rise_evt && cnt_reg < `BYTE_BITS) begin
            shift_next = {shift_reg[6:0], link_bit_reg};
            cnt_next   = cnt_reg + 4'h1;
          end else if (fall_evt && cnt_reg == `BYTE_BITS) begin
            cnt_next = 4'h0;
            if (state_reg == ST_WRITE_RX) begin
              drive_next = 1'b1;
              state_next = ST_ACK;
              rx_next    = {1'b1, shift_reg};
              wrote_next = 1'b1;
            end else if (shift_reg[`SEL_TYPE_MSB:`SEL_TYPE_LSB] == TYPE_CODE &&
                         shift_reg[`SEL_CS_MSB:`SEL_CS_LSB] == cs_s) begin
              drive_next = 1'b1;
              state_next = ST_ACK;
              rw_next    = shift_reg[`SEL_DIR_BIT];
              sel_next   = {1'b1, shift_reg[`SEL_DIR_BIT], shift_reg[`SEL_BLOCK_BIT]};
            end else begin
              state_next = ST_WAIT;
            end
          end
        end
        ST_ACK: begin
          if (fall_evt && rw_reg) begin
            shift_next   = tx_data_i;
            tx_take_next = 1'b1;
            drive_next   = ~tx_data_i[7];
            state_next   = ST_READ_TX;
          end else if (fall_evt) begin
            drive_next = 1'b0;
            state_next = ST_WRITE_RX;
          end
        end
        ST_READ_TX: begin
          if (rise_evt) begin
            cnt_next = cnt_reg + 4'h1;
          end else if (fall_evt && cnt_reg == `BYTE_BITS) begin
            drive_next = 1'b0;
            cnt_next   = 4'h0;
            state_next = ST_MACK;
          end else if (fall_evt) begin
            drive_next = ~shift_reg[6];
            shift_next = {shift_reg[6:0], 1'b1};
          end
        end
        ST_MACK: begin
          if (rise_evt) begin
            nack_next = link_bit_reg;
            cnt_next  = 4'h1;
          end else if (fall_evt && cnt_reg == 4'h1 && !nack_reg) begin
            shift_next   = tx_data_i;
            tx_take_next = 1'b1;
            drive_next   = ~tx_data_i[7];
            cnt_next     = 4'h0;
            state_next   = ST_READ_TX;
          end else if (fall_evt && cnt_reg == 4'h1) begin
            state_next = ST_WAIT;
          end
        end
        default: state_next = state_reg;
      endcase
    end
    if (state_next == ST_IDLE || state_next == ST_WAIT) begin
      drive_next = 1'b0;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg   <= ST_IDLE;
      cnt_reg     <= 4'h0;
      shift_reg   <= 8'h00;
      drive_reg   <= 1'b0;
      rw_reg      <= 1'b0;
      wrote_reg   <= 1'b0;
      nack_reg    <= 1'b0;
      sel_reg     <= '0;
      rx_reg      <= '0;
      tx_take_reg <= 1'b0;
      wstart_reg  <= 1'b0;
      standby_reg <= `STANDBY_RST;
    end else begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      shift_reg   <= shift_next;
      drive_reg   <= drive_next;
      rw_reg      <= rw_next;
      wrote_reg   <= wrote_next;
      nack_reg    <= nack_next;
      sel_reg     <= sel_next;
      rx_reg      <= rx_next;
      tx_take_reg <= tx_take_next;
      wstart_reg  <= wstart_next;
      standby_reg <= standby_next;
    end
  end
  // open drain: only ever pulls low, the clock line is never an output
  assign sda_o         = 1'b0;
  assign sda_oe_n_o    = ~drive_reg;
  assign sel_info_o    = sel_reg;
  assign rx_byte_o     = rx_reg;
  assign tx_take_o     = tx_take_reg;
  assign write_start_o = wstart_reg;
  assign standby_o     = standby_reg;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_reg);
  a_busy_start_ignored: assert property (write_busy_i |=> state_reg == ST_IDLE)
    else $error("start accepted during program cycle");
  a_busy_no_ack: assert property (write_busy_i |=> sda_oe_n_o)
    else $error("data driven during program cycle");
  a_start_enters: assert property (start_evt && !write_busy_i |=> state_reg == ST_SELECT && cnt_reg == 4'h0)
    else $error("start not taken");
  a_idle_silent: assert property (state_reg == ST_IDLE || state_reg == ST_WAIT |-> sda_oe_n_o)
    else $error("data driven without start or after mismatch");
  a_mismatch_release: assert property (state_reg == ST_SELECT && fall_evt && cnt_reg == `BYTE_BITS &&
      shift_reg[`SEL_CS_MSB:`SEL_CS_LSB] != cs_s && !write_busy_i && !start_evt && !stop_evt
      |=> state_reg == ST_WAIT ##1 sda_oe_n_o)
    else $error("mismatched select not ignored");
  a_select_ack: assert property (state_reg == ST_SELECT && fall_evt && cnt_reg == `BYTE_BITS &&
      shift_reg[7:4] == TYPE_CODE && shift_reg[3:2] == cs_s && !write_busy_i && !start_evt && !stop_evt
      |=> !sda_oe_n_o && sel_info_o.valid)
    else $error("matching select not acknowledged");
  a_ack_release: assert property (state_reg == ST_ACK && fall_evt && !rw_reg && !write_busy_i && !stop_evt && !start_evt
      |=> sda_oe_n_o && state_reg == ST_WRITE_RX)
    else $error("acknowledge not released after ninth clock");
  a_sample_rise: assert property (state_reg == ST_SELECT && rise_evt && cnt_reg < `BYTE_BITS &&
      !write_busy_i && !start_evt && !stop_evt |=> shift_reg[0] == $past(link_bit_reg))
    else $error("bit not sampled on rising clock");
  a_write_trigger: assert property (stop_evt && wrote_reg && !write_busy_i && !start_evt |=> write_start_o ##1 !write_start_o)
    else $error("write cycle not started by stop");
  a_read_standby: assert property (stop_evt && rw_reg && !nack_reg && state_reg != ST_IDLE && !write_busy_i
      |=> !standby_o && state_reg == ST_WAIT)
    else $error("standby entered without not-acknowledge");
  a_stop_ends: assert property (stop_evt && !write_busy_i |=> state_reg == ST_IDLE || state_reg == ST_WAIT)
    else $error("stop did not end the exchange");
  a_filter_hold: assert property ($changed(filt_reg[0]) |-> $past(pin_s2_reg[0], 1) == filt_reg[0] &&
      $past(pin_s2_reg[0], 2) == filt_reg[0])
    else $error("glitch filter passed a short pulse");
  c_select_write: cover property (sel_info_o.valid && !sel_info_o.read);
  c_read_nack_stop: cover property (state_reg == ST_WAIT && nack_reg ##[1:1000] standby_o);
  c_mismatch: cover property (state_reg == ST_SELECT ##1 state_reg == ST_WAIT);
  c_write_start: cover property (write_start_o);
endmodule

//--- design/eeprom_front_defines.svh
// constants of the two-wire slave front: field positions, reset values, timing
// assumes a 25 MHz system clock; included by its bare name
`ifndef EEPROM_FRONT_DEFINES_SVH
`define EEPROM_FRONT_DEFINES_SVH

`define CLK_NS        40
`define FILT_NS       100
// longest filter time rounds down to whole cycles, never below one
`define FILT_CYC      (((`FILT_NS / `CLK_NS) < 1) ? 1 : (`FILT_NS / `CLK_NS))

`define BYTE_BITS     4'h8
`define SEL_TYPE_MSB  7
`define SEL_TYPE_LSB  4
`define SEL_CS_MSB    3
`define SEL_CS_LSB    2
`define SEL_BLOCK_BIT 1
`define SEL_DIR_BIT   0

`define STANDBY_RST   1'b1

`endif

//--- design/front_pkg.sv
// types shared by the two-wire slave front and its surroundings
// assumes nothing beyond a SystemVerilog compiler
package front_pkg;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'h0,
    ST_SELECT   = 3'h1,
    ST_ACK      = 3'h2,
    ST_WRITE_RX = 3'h3,
    ST_READ_TX  = 3'h4,
    ST_MACK     = 3'h5,
    ST_WAIT     = 3'h6
  } state_t;

  typedef struct packed {
    logic valid;
    logic read;
    logic upper_half_select;
  } sel_info_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } rx_byte_t;

endpackage

//--- tb/two_wire_master_model.sv
// behavioural two-wire bus master: start, stop, byte out and byte in
// assumes a pull-up on data; the bench resolves the wire into sda_i
`timescale 1ns/10ps
module two_wire_master_model (
  input  wire logic sda_i,      // resolved data line
  output logic      scl_o,      // serial clock, high and still when idle
  output logic      sda_pull_o  // 1 pulls data low
);
  // bit clock is built from a 12 ns base so phases stay far above the filter
  localparam int Q = 50;
  logic base_clk;
  initial begin
    base_clk = 1'b0;
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
    #3;
    forever #6 base_clk = ~base_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge base_clk);
  endtask
  // data moves only mid low phase, held across the rising edge
  // each bit ends with the clock high; the next call makes the falling edge
  task automatic put_bit(input logic b);
    scl_o = 1'b0;
    tick(Q / 2);
    sda_pull_o = ~b;
    tick(Q / 2);
    scl_o = 1'b1;
    tick(Q);
  endtask
  // line released so the device may drive, sampled late in the high phase
  task automatic get_bit(output logic b);
    scl_o = 1'b0;
    sda_pull_o = 1'b0;
    tick(Q);
    scl_o = 1'b1;
    tick(Q);
    b = sda_i;
  endtask
  task automatic start_cond;
    tick(Q / 2);
    sda_pull_o = 1'b0;
    tick(Q / 2);
    scl_o = 1'b1;
    tick(Q);
    sda_pull_o = 1'b1;
    tick(Q);
  endtask
  task automatic stop_cond;
    scl_o = 1'b0;
    tick(Q / 2);
    sda_pull_o = 1'b1;
    tick(Q / 2);
    scl_o = 1'b1;
    tick(Q);
    sda_pull_o = 1'b0;
    tick(Q);
  endtask
  // data low for one base period with the clock high, far below the filter
  task automatic glitch;
    sda_pull_o = 1'b1;
    tick(1);
    sda_pull_o = 1'b0;
    tick(Q);
  endtask
  // most significant bit first, acknowledge read on the 9th clock
  task automatic put_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    get_bit(ack);
  endtask
  task automatic get_byte(input logic nack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      get_bit(d[i]);
    end
    put_bit(nack);
  endtask
endmodule

//--- tb/eeprom_two_wire_slave_front_test.sv
// self-checking bench of the two-wire slave front against a master model
// assumes front_pkg, the design and two_wire_master_model compiled first
`timescale 1ns/10ps
`define CHECK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; $display("ERROR %s expected %h seen %h", n, e, g); end end
module eeprom_two_wire_slave_front_test;
  import front_pkg::*;
  localparam logic [3:0] TYPE = 4'h9; // arbitrary type code
  logic       clk_i;
  logic       reset_n_i;
  logic       write_busy_i;
  logic [1:0] pins;
  logic [7:0] tx_data_i = 8'h3C;
  logic       scl, pull, sda, sda_o, sda_oe_n_o, tx_take_o, write_start_o, standby_o;
  sel_info_t  sel_info_o;
  rx_byte_t   rx_byte_o;
  int         errors = 0, samples_checked = 0, n_sel = 0, n_ws = 0, n_take = 0, n_rx = 0;
  assign sda = ~pull & (sda_oe_n_o | sda_o);
  eeprom_two_wire_slave_front #(.TYPE_CODE(TYPE)) i_dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .scl_clk_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o), .chip_select_pins_i(pins), .write_busy_i(write_busy_i),
    .tx_data_i(tx_data_i), .sel_info_o(sel_info_o), .rx_byte_o(rx_byte_o), .tx_take_o(tx_take_o),
    .write_start_o(write_start_o), .standby_o(standby_o));
  two_wire_master_model i_master (.sda_i(sda), .scl_o(scl), .sda_pull_o(pull));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // pulses are counted here so no scenario can miss a one-cycle strobe
  always @(posedge clk_i) begin
    n_sel <= n_sel + int'(sel_info_o.valid === 1'b1);
    n_ws <= n_ws + int'(write_start_o === 1'b1);
    n_take <= n_take + int'(tx_take_o === 1'b1);
    n_rx <= n_rx + int'(rx_byte_o.valid === 1'b1);
    if (tx_take_o === 1'b1) begin
      tx_data_i <= ~tx_data_i;
    end
  end
  task automatic results;
    if (errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic drive(input logic [1:0] p, input logic busy);
    @(posedge clk_i);
    #2;
    pins = p;
    write_busy_i = busy;
  endtask
  task automatic sel(input logic [1:0] c, input logic up, input logic rd, output logic ack);
    i_master.start_cond();
    i_master.put_byte({TYPE, c, up, rd}, ack);
  endtask
  task automatic t_idle;
    logic ack;
    `CHECK("standby", 1'b1, standby_o)
    `CHECK("sda_oe_n", 1'b1, sda_oe_n_o)
    `CHECK("sda_o", 1'b0, sda_o)
    i_master.glitch();
    `CHECK("glitch start", 1'b1, standby_o)
    i_master.put_byte({TYPE, pins, 2'b00}, ack);
    i_master.stop_cond();
    `CHECK("ack no start", 1'b1, ack)
    `CHECK("sel no start", 0, n_sel)
  endtask
  task automatic t_write;
    logic ack;
    int s, w, r;
    for (int c = 0; c < 4; c++) begin
      drive(2'(c), 1'b0);
      s = n_sel;
      w = n_ws;
      r = n_rx;
      sel(2'(c), c[0], 1'b0, ack);
      `CHECK("sel ack", 1'b0, ack)
      `CHECK("standby start", 1'b0, standby_o)
      `CHECK("sel pulses", s + 1, n_sel)
      `CHECK("sel read", 1'b0, sel_info_o.read)
      `CHECK("sel half", c[0], sel_info_o.upper_half_select)
      i_master.put_byte(8'hA5 ^ 8'(c), ack);
      `CHECK("data ack", 1'b0, ack)
      `CHECK("rx data", 8'hA5 ^ 8'(c), rx_byte_o.data)
      `CHECK("rx pulses", r + 1, n_rx)
      i_master.stop_cond();
      `CHECK("write start", w + 1, n_ws)
      `CHECK("standby stop", 1'b1, standby_o)
    end
  endtask
  task automatic t_mismatch;
    logic ack;
    int s, w;
    s = n_sel;
    w = n_ws;
    drive(2'b10, 1'b0);
    sel(2'b01, 1'b0, 1'b0, ack);
    `CHECK("cs mismatch ack", 1'b1, ack)
    i_master.put_byte(8'h00, ack);
    `CHECK("released after mismatch", 1'b1, ack)
    i_master.stop_cond();
    i_master.start_cond();
    i_master.put_byte({~TYPE, pins, 2'b00}, ack);
    i_master.stop_cond();
    `CHECK("type mismatch ack", 1'b1, ack)
    `CHECK("mismatch pulses", s, n_sel)
    `CHECK("mismatch write", w, n_ws)
    sel(2'b10, 1'b0, 1'b0, ack);
    i_master.stop_cond();
    `CHECK("bare select ack", 1'b0, ack)
    `CHECK("bare select write", w, n_ws)
  endtask
  // second byte keeps bit 7 high so a STOP after an ack is not masked
  task automatic t_read(input logic nack_last);
    logic ack;
    logic [7:0] d, e;
    int t;
    e = tx_data_i;
    t = n_take;
    sel(pins, 1'b1, 1'b1, ack);
    `CHECK("read sel ack", 1'b0, ack)
    `CHECK("sel read", 1'b1, sel_info_o.read)
    i_master.get_byte(1'b0, d);
    `CHECK("read byte 1", e, d)
    if (nack_last) begin
      i_master.get_byte(1'b1, d);
      `CHECK("read byte 2", ~e, d)
    end
    i_master.stop_cond();
    `CHECK("read loads", t + 2, n_take)
    `CHECK("read standby", nack_last, standby_o)
  endtask
  task automatic t_busy;
    logic ack;
    int s;
    s = n_sel;
    drive(pins, 1'b1);
    sel(pins, 1'b0, 1'b0, ack);
    i_master.stop_cond();
    `CHECK("busy ack", 1'b1, ack)
    `CHECK("busy pulses", s, n_sel)
    drive(pins, 1'b0);
    sel(pins, 1'b0, 1'b0, ack);
    i_master.stop_cond();
    `CHECK("poll ack", 1'b0, ack)
  endtask
  initial begin
    reset_n_i = 1'b0;
    write_busy_i = 1'b0;
    pins = 2'b00;
    repeat (12) @(posedge clk_i);
    #2;
    reset_n_i = 1'b1;
    repeat (6) @(posedge clk_i);
    t_idle();
    t_write();
    t_mismatch();
    t_read(1'b1);
    t_read(1'b0);
    t_busy();
    results();
  end
  initial begin
    repeat (30000) @(posedge clk_i);
    errors++;
    results();
  end
endmodule
